// *** rgbp_pkg.sv ***
`default_nettype none

package rgbp_pkg;
  // ===========================================================
  // Clock and link timing
  localparam int MCLK_PERIOD_NS   = 5;
  localparam int LINK_PERIOD_NS   = 80;
  localparam int LINK_HALF_CYC    = LINK_PERIOD_NS / 2 / MCLK_PERIOD_NS;
  localparam int FWD_CLK_DELAY    = 4;
  // ===========================================================
  // Frame layout
  localparam int START_FRAME_BITS = 32;
  localparam int FRAME_BITS       = 16;
  localparam int GREY_W           = 5;
  localparam int NUM_CH           = 3;
  localparam int GREY_ALL_W       = GREY_W * NUM_CH;
  localparam int WORD_W           = GREY_ALL_W + 1;
  localparam int APPEND_PULSES    = 4;
  // ===========================================================
  // Grey-level stage and controller word buffer
  localparam int PWM_W            = 8;
  localparam int OSC_DIV          = 4;
  localparam int FIFO_DEPTH       = 4;
  localparam logic [GREY_ALL_W-1:0] GREY_RESET = 15'h0000;

  typedef enum {RX_HUNT, RX_OWN, RX_PASS} rgbp_rx_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_APPEND} rgbp_tx_t;
endpackage

`default_nettype wire

// *** rgbp_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface rgbp_link_if;
  logic sdata;
  logic sclk;
  modport ctrl (output sdata, output sclk);
  modport dev  (input sdata, input sclk);
endinterface

`default_nettype wire

// *** rgbp_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none

module rgbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg    <= count_next;
      in_ready_out <= (count_next != (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule

`default_nettype wire

// *** rgbp_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none

module rgbp_ctrl (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_b_in,
  // Link towards the first driver
  rgbp_link_if.ctrl                       link,
  // Frame words: bit 15 marks the last chip, bits 14:0 the grey values
  input  wire logic [rgbp_pkg::WORD_W-1:0] word_in,
  input  wire logic                       word_valid_in,
  output logic                            word_ready_out,
  // Status
  output logic                            busy_out
);
  import rgbp_pkg::*;

  rgbp_tx_t                 state_reg;
  logic [5:0]               div_reg;
  logic [5:0]               bit_cnt_reg;
  logic [GREY_ALL_W-1:0]    shift_reg;
  logic                     last_reg;
  logic                     sclk_reg;
  logic                     sdata_reg;
  logic [WORD_W-1:0]        fifo_data;
  logic                     fifo_valid;
  logic                     tick;
  logic                     fall;
  logic                     pop;

  rgbp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) rgbp_fifo_inst (
    .mclk_in       (mclk_in),
    .rst_b_in      (rst_b_in),
    .in_data_in    (word_in),
    .in_valid_in   (word_valid_in),
    .in_ready_out  (word_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop)
  );

  assign tick = (state_reg != TX_IDLE) && (div_reg == 6'(LINK_HALF_CYC - 1));
  // Data changes only on the falling half, so it is stable at each rise.
  assign fall = tick && sclk_reg; // see (RULE3)
  assign pop  = fall && fifo_valid &&
                (((state_reg == TX_START) &&
                  (bit_cnt_reg == 6'(START_FRAME_BITS - 1))) ||
                 ((state_reg == TX_DATA) && !last_reg &&
                  (bit_cnt_reg == 6'(FRAME_BITS - 1))));

  assign link.sclk  = sclk_reg;
  assign link.sdata = sdata_reg;

  // ===========================================================
  // Link clock divider
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
    end else if (state_reg == TX_IDLE) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
    end else if (tick) begin
      div_reg  <= '0;
      sclk_reg <= ~sclk_reg;
    end else begin
      div_reg  <= div_reg + 1'b1;
    end
  end

  // ===========================================================
  // Frame sequencer
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg   <= TX_IDLE;
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
      last_reg    <= 1'b0;
      sdata_reg   <= 1'b0;
      busy_out    <= 1'b0;
    end else begin
      case (state_reg)
        TX_IDLE: begin
          sdata_reg <= 1'b0;
          if (fifo_valid) begin
            state_reg   <= TX_START; // see (RULE1)
            bit_cnt_reg <= '0;
            busy_out    <= 1'b1;
          end
        end
        TX_START: begin
          if (fall) begin
            if (bit_cnt_reg == 6'(START_FRAME_BITS - 1)) begin
              // The first word popped goes to the nearest chip.
              state_reg   <= TX_DATA; // see (RULE4)
              bit_cnt_reg <= '0;
              shift_reg   <= fifo_data[GREY_ALL_W-1:0];
              last_reg    <= fifo_data[WORD_W-1];
              sdata_reg   <= 1'b1; // see (RULE5)
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              sdata_reg   <= 1'b0;
            end
          end
        end
        TX_DATA: begin
          if (fall) begin
            if (bit_cnt_reg == 6'(FRAME_BITS - 1)) begin
              bit_cnt_reg <= '0;
              if (pop) begin
                shift_reg <= fifo_data[GREY_ALL_W-1:0];
                last_reg  <= fifo_data[WORD_W-1];
                sdata_reg <= 1'b1; // see (RULE5)
              end else begin
                // An empty buffer before the last word ends the update.
                state_reg <= TX_APPEND; // see (RULE6)
                sdata_reg <= 1'b0;
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              sdata_reg   <= shift_reg[GREY_ALL_W-1]; // see (RULE2)
              shift_reg   <= {shift_reg[GREY_ALL_W-2:0], 1'b0};
            end
          end
        end
        TX_APPEND: begin
          sdata_reg <= 1'b0;
          if (fall) begin
            if (bit_cnt_reg == 6'(APPEND_PULSES - 1)) begin
              state_reg <= TX_IDLE;
              busy_out  <= 1'b0;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1; // see (RULE6)
            end
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// *** rgbp_dev.sv ***
// Functional notes
// (RULE1) Update opens with thirty-two zero bits.
// (RULE2) All frames travel most significant bit first.
// (RULE3) Bits are taken on shift clock rise.
// (RULE4) First frame belongs to the nearest chip.
// (RULE5) Frame: one start bit, three grey fields.
// (RULE6) Appended pulses move received values into PWM.
// (RULE7) Grading pin high linear, low inverse gamma.
// (RULE8) Polarity pin high sink, low inverted drive.
// (RULE9) Grey clock select: low shift, high oscillator.
// (RULE10) Regenerated shift clock drives the next chip.
// (RULE11) Serial data forwarded on the data output.
// (RULE12) Shifting and PWM counting use independent clocks.
// (RULE13) Own first frame consumed, others passed through.
// (RULE14) Duty follows grey value; zero stays off.
`timescale 1ns/100ps
`default_nettype none

module rgbp_dev (
  // Clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_b_in,
  // Link from the controller or previous chip
  rgbp_link_if.dev                      link,
  // Mode pins
  input  wire logic                     grading_select_in,
  input  wire logic                     polarity_select_in,
  input  wire logic                     grey_clock_select_in,
  // Chain outputs towards the next chip
  output logic                          data_forward_out,
  output logic                          shift_clock_forward_out,
  // Channel drives, index 0 is channel 1
  output logic [rgbp_pkg::NUM_CH-1:0]   channel_drive_out
);
  import rgbp_pkg::*;

  // Five-bit grey value to an eight-bit on-time out of 256 steps.
  // Gamma squares the value and scales it so that 31 reaches 255.
  function automatic logic [PWM_W-1:0] grey_level(
    input logic [GREY_W-1:0] g,
    input logic              linear
  );
    logic [14:0] sq;
    sq = 15'(g) * 15'(g) * 15'd17;
    if (linear) begin
      grey_level = {g, g[4:2]};
    end else begin
      grey_level = sq[13:6];
    end
  endfunction

  logic                        sclk_s1_reg;
  logic                        sclk_s2_reg;
  logic                        sclk_s3_reg;
  logic                        sdat_s1_reg;
  logic                        sdat_s2_reg;
  logic [2:0]                  mode_s1_reg;
  logic [2:0]                  mode_s2_reg;
  logic                        rise;
  rgbp_rx_t                    state_reg;
  logic [5:0]                  zero_cnt_reg;
  logic [3:0]                  bit_cnt_reg;
  logic [GREY_ALL_W-1:0]       shadow_reg;
  logic [GREY_ALL_W-1:0]       grey_reg;
  logic [FWD_CLK_DELAY-1:0]    clk_dly_reg;
  logic [$clog2(OSC_DIV)-1:0]  osc_cnt_reg;
  logic                        osc_tick;
  logic                        grey_tick;
  logic [PWM_W-1:0]            pwm_cnt_reg;

  // ===========================================================
  // Pin synchronisers
  // The mode pins are loose straps, so they get the same two-stage
  // synchroniser as the link; a change reaches mode_s2_reg two clocks later.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      sdat_s1_reg <= 1'b0;
      sdat_s2_reg <= 1'b0;
      mode_s1_reg <= '0;
      mode_s2_reg <= '0;
    end else begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdat_s1_reg <= link.sdata;
      sdat_s2_reg <= sdat_s1_reg;
      mode_s1_reg <= {grey_clock_select_in, polarity_select_in,
                      grading_select_in};
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // The third clock stage feeds only the edge detector and the
  // regenerated clock, so data and clock keep an equal delay.
  assign rise = sclk_s2_reg && !sclk_s3_reg; // see (RULE3)

  // ===========================================================
  // Frame receiver and forwarder
  // A zero where a frame's start bit is due means the frames are over,
  // so that bit is taken as the first appended pulse.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg        <= RX_HUNT;
      zero_cnt_reg     <= '0;
      bit_cnt_reg      <= '0;
      shadow_reg       <= '0;
      grey_reg         <= GREY_RESET;
      data_forward_out <= 1'b0;
    end else if (rise) begin
      case (state_reg)
        RX_HUNT: begin
          data_forward_out <= sdat_s2_reg; // see (RULE13)
          if (!sdat_s2_reg) begin
            if (zero_cnt_reg != 6'(START_FRAME_BITS)) begin
              zero_cnt_reg <= zero_cnt_reg + 1'b1; // see (RULE1)
            end
          end else if (zero_cnt_reg == 6'(START_FRAME_BITS)) begin
            // The start bit of the first frame is ours and is not passed.
            state_reg        <= RX_OWN; // see (RULE4)
            bit_cnt_reg      <= 4'h1; // see (RULE5)
            zero_cnt_reg     <= '0;
            data_forward_out <= 1'b0;
          end else begin
            zero_cnt_reg <= '0;
          end
        end
        RX_OWN: begin
          data_forward_out <= 1'b0; // see (RULE13)
          shadow_reg       <= {shadow_reg[GREY_ALL_W-2:0], sdat_s2_reg}; // see (RULE2)
          bit_cnt_reg      <= bit_cnt_reg + 1'b1;
          if (bit_cnt_reg == 4'(FRAME_BITS - 1)) begin
            state_reg <= RX_PASS;
          end
        end
        RX_PASS: begin
          // Only a frame boundary can end the update; a zero inside a
          // passed frame is ordinary data.
          if ((bit_cnt_reg == '0) && !sdat_s2_reg) begin
            grey_reg         <= shadow_reg; // see (RULE6)
            state_reg        <= RX_HUNT;
            zero_cnt_reg     <= 6'h01;
            data_forward_out <= 1'b0;
          end else begin
            data_forward_out <= sdat_s2_reg; // see (RULE11)
            bit_cnt_reg      <= bit_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= RX_HUNT;
      endcase
    end
  end

  // ===========================================================
  // Regenerated clock
  // Delaying the rise lets the forwarded bit settle before the next
  // chip samples it; the delay must stay under half a link period.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_dly_reg             <= '0;
      shift_clock_forward_out <= 1'b0;
    end else begin
      clk_dly_reg             <= {clk_dly_reg[FWD_CLK_DELAY-2:0], sclk_s3_reg};
      shift_clock_forward_out <= clk_dly_reg[FWD_CLK_DELAY-1]; // see (RULE10)
    end
  end

  // ===========================================================
  // Grey clock and PWM
  assign osc_tick  = (osc_cnt_reg == ($clog2(OSC_DIV))'(OSC_DIV - 1));
  // With the shift clock selected the PWM only advances while it runs.
  assign grey_tick = mode_s2_reg[2] ? osc_tick : rise; // see (RULE9)

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_tick ? '0 : osc_cnt_reg + 1'b1;
    end
  end

  // The counter runs on; a value latched mid-period can stretch one
  // pulse once, which beats holding the latch back a whole period.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_cnt_reg <= '0;
    end else if (grey_tick) begin
      pwm_cnt_reg <= pwm_cnt_reg + 1'b1; // see (RULE12)
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel_drive_out <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // Channel 1 is the first grey field after the start bit.
        channel_drive_out[i] <=
          (pwm_cnt_reg < grey_level(grey_reg[GREY_W*(NUM_CH-i)-1 -: GREY_W],
                                    mode_s2_reg[0])) // see (RULE7) (RULE14)
          ^ !mode_s2_reg[1]; // see (RULE8)
      end
    end
  end
endmodule

`default_nettype wire

// *** rgbp_link_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none

module rgbp_link_monitor (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  // Link wires
  input  wire logic sdata,
  input  wire logic sclk,
  // Controller user side
  input  wire logic word_valid_in,
  input  wire logic word_ready_out,
  input  wire logic busy_out,
  // Driver chain output
  input  wire logic shift_clock_forward_out
);
  logic       sclk_q;
  logic [7:0] rise_idx;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // ===========================================================
  // Helper logic
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  // Rise index within the update; the counter saturates so a long chain
  // cannot wrap it back into the start frame.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) rise_idx <= 8'h00;
    else if (!busy_out) rise_idx <= 8'h00;
    else if (sclk && !sclk_q && rise_idx != 8'hff) rise_idx <= rise_idx + 8'h01;
  end

  // ===========================================================
  // Assertions
  a_sdata_at_fall:
    assert property ($changed(sdata) |-> $fell(sclk))
    else $error("link data moved away from a clock fall");
  a_clk_high_width:
    assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase is not eight cycles");
  a_clk_low_width:
    assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase shorter than eight cycles");
  a_clk_idle_low:
    assert property (!busy_out |-> !sclk)
    else $error("link clock high outside an update");
  a_start_zeros:
    assert property (sclk && !sclk_q && rise_idx < 8'h20 |-> !sdata)
    else $error("start frame bit is not zero");
  a_start_bit_one:
    assert property (sclk && !sclk_q && rise_idx == 8'h20 |-> sdata)
    else $error("first frame does not open with a one");
  a_busy_after_push:
    assert property (!busy_out && word_valid_in && word_ready_out |-> ##2 busy_out)
    else $error("update did not start two cycles after a push");
  a_fwd_clk_delay:
    assert property (shift_clock_forward_out == $past(sclk, 8))
    else $error("forwarded clock is not the link clock eight cycles late");
  a_ready_after_rst:
    assert property ($rose(rst_b_in) |=> word_ready_out)
    else $error("word ready missing after reset release");
endmodule

`default_nettype wire

// *** tb_cascaded_rgb_pwm_led_driver.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_cascaded_rgb_pwm_led_driver;
  import rgbp_pkg::*;
  typedef struct packed {
    logic [14:0] grey;
    logic        lin;
    logic        pol;
    logic        gsel;
    logic [23:0] lvls;
  } rgbp_row_t;

  logic              mclk_in;
  logic              rst_b_in;
  logic [WORD_W-1:0] word_in;
  logic              word_valid_in;
  logic              word_ready_out;
  logic              busy_out;
  logic              grading_select_in;
  logic              polarity_select_in;
  logic              grey_clock_select_in;
  logic              data_forward_out;
  logic              shift_clock_forward_out;
  logic [NUM_CH-1:0] channel_drive_out;
  logic [31:0]       fwd_cap;
  logic              taken;
  int                fwd_cnt;
  int                err_total;
  int                n_compared;
  int                i;
  rgbp_row_t         rows [5];

  rgbp_link_if rgbp_link_if_inst ();
  rgbp_ctrl rgbp_ctrl_inst (.mclk_in, .rst_b_in, .link(rgbp_link_if_inst),
    .word_in, .word_valid_in, .word_ready_out, .busy_out);
  rgbp_dev rgbp_dev_inst (.mclk_in, .rst_b_in, .link(rgbp_link_if_inst),
    .grading_select_in, .polarity_select_in, .grey_clock_select_in,
    .data_forward_out, .shift_clock_forward_out, .channel_drive_out);
  rgbp_link_monitor rgbp_link_monitor_inst (.mclk_in, .rst_b_in,
    .sdata(rgbp_link_if_inst.sdata), .sclk(rgbp_link_if_inst.sclk),
    .word_valid_in, .word_ready_out, .busy_out, .shift_clock_forward_out);

  initial begin
    mclk_in = 1'b0;
    forever #(MCLK_PERIOD_NS / 2.0) mclk_in = ~mclk_in;
  end

  // Bits 32..63 of the forwarded stream: our own slot, then the next frame.
  always @(posedge shift_clock_forward_out) begin
    if (fwd_cnt >= 32 && fwd_cnt < 64) fwd_cap = {fwd_cap[30:0], data_forward_out};
    fwd_cnt++;
  end

  // ===========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Ready is a register, so its level at the falling edge is what the
  // next rising edge samples.
  task automatic push(input logic [WORD_W-1:0] w, input int lim);
    int j;
    word_in <= w;
    word_valid_in <= 1'b1;
    taken = 1'b0;
    for (j = 0; j < lim && !taken; j++) begin
      @(negedge mclk_in);
      taken = (word_ready_out === 1'b1);
    end
    if (taken) @(posedge mclk_in);
  endtask

  task automatic run_update;
    int j;
    for (j = 0; j < 200 && busy_out !== 1'b1; j++) @(negedge mclk_in);
    for (j = 0; j < 8000 && busy_out !== 1'b0; j++) @(negedge mclk_in);
    // A busy flag that never rose leaves j at zero.
    if (j == 0 || busy_out !== 1'b0) begin
      err_total++;
      stop_test;
    end
    repeat (32) @(posedge mclk_in);
  endtask

  // An unknown drive level adds a large penalty so it can never match.
  task automatic measure(input logic [23:0] lvls, input logic pol);
    int act [3];
    int c;
    int j;
    int e;
    act = '{0, 0, 0};
    for (j = 0; j < 256 * OSC_DIV; j++) begin
      @(negedge mclk_in);
      for (c = 0; c < 3; c++) begin
        act[c] += (channel_drive_out[c] === pol) ? 1 :
                  (channel_drive_out[c] === ~pol) ? 0 : 4096;
      end
    end
    for (c = 0; c < 3; c++) begin
      e = int'(lvls[23-8*c -: 8]) * OSC_DIV;
      chk("channel_on_cycles", e, act[c]);
    end
    @(posedge mclk_in);
  endtask

  // ===========================================================
  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    word_in = '0;
    word_valid_in = 1'b0;
    grading_select_in = 1'b1;
    polarity_select_in = 1'b1;
    grey_clock_select_in = 1'b1;
    fwd_cnt = 0;
    fwd_cap = '0;
    err_total = 0;
    n_compared = 0;
    // Each row: grey word, modes, then the three expected on-levels.
    rows = '{'{15'h7c10, 1'b1, 1'b1, 1'b1, 24'hff0084},
             '{15'h7c10, 1'b0, 1'b0, 1'b1, 24'hff0044},
             '{15'h045e, 1'b1, 1'b1, 1'b1, 24'h0810f7},
             '{15'h045e, 1'b0, 1'b0, 1'b1, 24'h0001ef},
             '{15'h0000, 1'b1, 1'b0, 1'b0, 24'h000000}};
    repeat (6) @(posedge mclk_in);
    chk("reset_outputs", 0, {busy_out, word_ready_out, data_forward_out,
        shift_clock_forward_out, channel_drive_out, rgbp_link_if_inst.sclk});
    rst_b_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    for (i = 0; i < 5; i++) begin
      grading_select_in <= rows[i].lin;
      polarity_select_in <= rows[i].pol;
      grey_clock_select_in <= rows[i].gsel;
      push({1'b1, rows[i].grey}, 100);
      word_valid_in <= 1'b0;
      run_update();
      measure(rows[i].lvls, rows[i].pol);
    end
    // Two-chip chain: our frame first, the far chip's frame passed on.
    grading_select_in <= 1'b1;
    polarity_select_in <= 1'b1;
    grey_clock_select_in <= 1'b1;
    fwd_cnt = 0;
    push(16'h0421, 100);
    push({1'b1, 15'h7c1f}, 100);
    word_valid_in <= 1'b0;
    run_update();
    chk("forwarded_stream", {16'h0000, 1'b1, 15'h7c1f}, fwd_cap);
    measure(24'h080808, 1'b1);
    // Fill the word buffer until it refuses, then let the link drain it.
    taken = 1'b1;
    for (i = 0; i < 8 && taken; i++) push(16'h0421, 1);
    if (!taken) @(posedge mclk_in);
    word_valid_in <= 1'b0;
    chk("fifo_refused", 0, taken);
    run_update();
    chk("fifo_drained", 1, word_ready_out);
    measure(24'h080808, 1'b1);
    // Reset in mid-update: all returns to idle and the grey values clear.
    // Reset outlasts the forwarded clock delay, then a fresh update lands.
    push({1'b1, 15'h7c1f}, 100);
    word_valid_in <= 1'b0;
    repeat (200) @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    chk("reset_mid_update", 0, {busy_out, word_ready_out, data_forward_out,
        shift_clock_forward_out, channel_drive_out, rgbp_link_if_inst.sclk});
    rst_b_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    chk("ready_after_reset", 1, word_ready_out);
    repeat (4) @(posedge mclk_in);
    measure(24'h000000, 1'b1);
    push({1'b1, 15'h0421}, 100);
    word_valid_in <= 1'b0;
    run_update();
    measure(24'h080808, 1'b1);
    stop_test();
  end
endmodule

`default_nettype wire
